// ==== hw/cevm_top.sv ====
// charger event mask registers gating event pulses onto the interrupt output
// Notes on behaviour
// - a bit7 clear lets current regulation entry pulse the interrupt
// - a bit6 clear lets voltage regulation entry pulse the interrupt
// - a bit5 clear lets watchdog expiry pulse the interrupt
// - a bit4 clear lets weak source detection raise the interrupt
// - a bit3 clear lets each power good toggle raise the interrupt
// - a bits2,1 gate second and first input presence changes
// - a bit0 clear lets bus supply presence change raise the interrupt
// - all masks zero after power-on reset and after register reset command
// - b bit7 clear lets charging status change raise the interrupt
// - b bit6 clear lets current optimizer status change interrupt
// - b bit4 clear lets bus supply status change interrupt
// - b bit2 clear lets thermal regulation entry interrupt
// - b bit1 clear lets battery presence change interrupt
// - b bit0 clear lets detection status change interrupt
// - c bit6 clear lets data line detection done pulse interrupt
// - c bit5 clear lets single-shot conversion done pulse interrupt
// - c bit4 clear lets min system regulation enter or exit pulse
// - c bits3,2 gate fast charge and trickle timer expiry
// - c bits1,0 gate precharge and topoff timer expiry
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cevm_top (
	input  wire logic                     clock_in,
	input  wire logic                     nrst_in,
	input  wire logic                     clk_en_in,
	input  wire cevm_pkg::cevm_bus_t      bus_in,
	output logic [7:0]                    rdata_out,
	input  wire cevm_pkg::cevm_evt_t      evt_in,
	output logic [cevm_pkg::NUM_EVT-1:0]  flags_out,
	output logic                          int_out
);
	logic [7:0]                   mask_a_r;
	logic [7:0]                   mask_b_r;
	logic [7:0]                   mask_c_r;
	logic [7:0]                   rdata_r;
	logic                         int_r;
	logic [cevm_pkg::NUM_EVT-1:0] flags_r;
	logic [cevm_pkg::NUM_EVT-1:0] flags_nxt;
	logic [7:0]                   rdata_nxt;

	wire logic        wr_a   = bus_in.wr && bus_in.addr == cevm_pkg::OFS_MASK_A;
	wire logic        wr_b   = bus_in.wr && bus_in.addr == cevm_pkg::OFS_MASK_B;
	wire logic        wr_c   = bus_in.wr && bus_in.addr == cevm_pkg::OFS_MASK_C;
	wire logic        reg_rst = bus_in.wr &&
		bus_in.addr == cevm_pkg::OFS_CTRL &&
		bus_in.wdata[cevm_pkg::CTRL_REG_RST];
	wire logic [23:0] evt_v  = evt_in;
	wire logic [23:0] mask_v = {mask_c_r, mask_b_r, mask_a_r};
	// unmasked events per bit, all three registers
	wire logic [23:0] pass_v = evt_v & ~mask_v;
	wire logic        int_nxt = |pass_v;
	// flags record regardless of mask, held until power-on reset (reads do not clear)
	assign flags_nxt = flags_r | evt_v;

	always_comb begin
		case (bus_in.addr)
		cevm_pkg::OFS_MASK_A: rdata_nxt = mask_a_r;
		cevm_pkg::OFS_MASK_B: rdata_nxt = mask_b_r;
		cevm_pkg::OFS_MASK_C: rdata_nxt = mask_c_r;
		default:              rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mask_a_r <= cevm_pkg::RST_MASK;
			mask_b_r <= cevm_pkg::RST_MASK;
			mask_c_r <= cevm_pkg::RST_MASK;
		end else if (clk_en_in) begin
			if (reg_rst) begin
				mask_a_r <= cevm_pkg::RST_MASK;
				mask_b_r <= cevm_pkg::RST_MASK;
				mask_c_r <= cevm_pkg::RST_MASK;
			end else begin
				if (wr_a)
					mask_a_r <= bus_in.wdata & cevm_pkg::WR_MASK_A;
				if (wr_b)
					mask_b_r <= bus_in.wdata & cevm_pkg::WR_MASK_B;
				if (wr_c)
					mask_c_r <= bus_in.wdata & cevm_pkg::WR_MASK_C;
			end
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flags_r <= cevm_pkg::RST_FLAGS;
			rdata_r <= 8'h00;
			int_r   <= 1'b0;
		end else if (clk_en_in) begin
			flags_r <= flags_nxt;
			rdata_r <= bus_in.rd ? rdata_nxt : 8'h00;
			int_r   <= int_nxt;
		end
	end

	assign rdata_out = rdata_r;
	assign flags_out = flags_r;
	assign int_out   = int_r;

	// assertions
	property p_no_event;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && (evt_v & ~mask_v) == 24'h000000 |=> !int_r;
	endproperty
	a_no_event: assert property (p_no_event)
		else $error("interrupt without an unmasked event");
	property p_mask_blocks;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && mask_a_r[7] && evt_v == 24'h000080 |=> !int_out;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("masked current regulation pulsed");
	property p_a7;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[7] && evt_v[7] |=> int_out;
	endproperty
	a_a7: assert property (p_a7)
		else $error("current regulation entry did not pulse");
	property p_a6;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[6] && evt_v[6] |=> int_out;
	endproperty
	a_a6: assert property (p_a6)
		else $error("voltage regulation entry did not pulse");
	property p_a5;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[5] && evt_v[5] |=> int_out;
	endproperty
	a_a5: assert property (p_a5)
		else $error("watchdog expiry did not pulse");
	property p_a4;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[4] && evt_v[4] |=> int_out;
	endproperty
	a_a4: assert property (p_a4)
		else $error("weak source did not pulse");
	property p_a3;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[3] && evt_v[3] |=> int_out;
	endproperty
	a_a3: assert property (p_a3)
		else $error("power good toggle did not pulse");
	property p_a2;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[2] && evt_v[2] |=> int_out;
	endproperty
	a_a2: assert property (p_a2)
		else $error("second input presence did not pulse");
	property p_a1;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[1] && evt_v[1] |=> int_out;
	endproperty
	a_a1: assert property (p_a1)
		else $error("first input presence did not pulse");
	property p_a0;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_a_r[0] && evt_v[0] |=> int_out;
	endproperty
	a_a0: assert property (p_a0)
		else $error("bus supply presence did not pulse");
	property p_b7;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[7] && evt_v[15] |=> int_out;
	endproperty
	a_b7: assert property (p_b7)
		else $error("charge status change did not pulse");
	property p_b6;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[6] && evt_v[14] |=> int_out;
	endproperty
	a_b6: assert property (p_b6)
		else $error("optimizer status did not pulse");
	property p_b4;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[4] && evt_v[12] |=> int_out;
	endproperty
	a_b4: assert property (p_b4)
		else $error("bus supply status did not pulse");
	property p_b2;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[2] && evt_v[10] |=> int_out;
	endproperty
	a_b2: assert property (p_b2)
		else $error("thermal regulation did not pulse");
	property p_b1;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[1] && evt_v[9] |=> int_out;
	endproperty
	a_b1: assert property (p_b1)
		else $error("battery presence did not pulse");
	property p_b0;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_b_r[0] && evt_v[8] |=> int_out;
	endproperty
	a_b0: assert property (p_b0)
		else $error("detection status did not pulse");
	property p_c6;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[6] && evt_v[22] |=> int_out;
	endproperty
	a_c6: assert property (p_c6)
		else $error("detection done did not pulse");
	property p_c5;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[5] && evt_v[21] |=> int_out;
	endproperty
	a_c5: assert property (p_c5)
		else $error("conversion done did not pulse");
	property p_c4;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[4] && evt_v[20] |=> int_out;
	endproperty
	a_c4: assert property (p_c4)
		else $error("min system regulation did not pulse");
	property p_c3;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[3] && evt_v[19] |=> int_out;
	endproperty
	a_c3: assert property (p_c3)
		else $error("fast charge timer did not pulse");
	property p_c2;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[2] && evt_v[18] |=> int_out;
	endproperty
	a_c2: assert property (p_c2)
		else $error("trickle timer did not pulse");
	property p_c1;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[1] && evt_v[17] |=> int_out;
	endproperty
	a_c1: assert property (p_c1)
		else $error("precharge timer did not pulse");
	property p_c0;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && !mask_c_r[0] && evt_v[16] |=> int_out;
	endproperty
	a_c0: assert property (p_c0)
		else $error("topoff timer did not pulse");
	property p_rst_cmd;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && reg_rst |=> mask_v == 24'h000000;
	endproperty
	a_rst_cmd: assert property (p_rst_cmd)
		else $error("register reset left a mask set");
	property p_resv;
		@(posedge clock_in) disable iff (!nrst_in)
		mask_b_r[5] == 1'b0 && mask_b_r[3] == 1'b0 && mask_c_r[7] == 1'b0;
	endproperty
	a_resv: assert property (p_resv)
		else $error("reserved mask bit set");
	property p_flag;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && evt_v[0] |=> flags_r[0];
	endproperty
	a_flag: assert property (p_flag)
		else $error("event flag lost under mask");
	property p_rd;
		@(posedge clock_in) disable iff (!nrst_in)
		clk_en_in && bus_in.rd && bus_in.addr == cevm_pkg::OFS_MASK_A
		|=> rdata_out == $past(mask_a_r);
	endproperty
	a_rd: assert property (p_rd)
		else $error("read data wrong");
	property p_freeze;
		@(posedge clock_in) disable iff (!nrst_in)
		!clk_en_in |=> mask_v == $past(mask_v) && int_out == $past(int_out);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
	c_freeze: cover property (@(posedge clock_in) !clk_en_in && bus_in.wr);
	c_int: cover property (@(posedge clock_in) int_out);
	c_masked: cover property (@(posedge clock_in) evt_v != 24'h0 && !int_nxt);
	c_rst: cover property (@(posedge clock_in) reg_rst && mask_v != 24'h0);
endmodule
`default_nettype wire

// ==== hw/cevm_pkg.sv ====
// package: offsets, field positions, reset values and carriers for the masks
package cevm_pkg;
	localparam logic [7:0] OFS_MASK_A = 8'h28;
	localparam logic [7:0] OFS_MASK_B = 8'h29;
	localparam logic [7:0] OFS_MASK_C = 8'h2A;
	localparam logic [7:0] OFS_CTRL   = 8'h2E;
	localparam logic [7:0] RST_MASK   = 8'h00;
	// writable bits of each mask
	localparam logic [7:0] WR_MASK_A  = 8'hFF;
	localparam logic [7:0] WR_MASK_B  = 8'hD7;
	localparam logic [7:0] WR_MASK_C  = 8'h7F;
	// control register bit positions
	localparam int         CTRL_REG_RST = 0;
	localparam int         NUM_EVT      = 24;
	localparam logic [NUM_EVT-1:0] RST_FLAGS = 24'h000000;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cevm_bus_t;

	// event index = register index * 8 + bit
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} cevm_evt_t;
endpackage

// ==== verif/cevm_host.sv ====
// host model counting clock cycles with the interrupt high
`timescale 1ns/1ps
`default_nettype none
module cevm_host (
	input  wire logic clock_in,
	input  wire logic int_in,
	output var  int   n_int_out
);
	always @(posedge clock_in) begin
		if (int_in === 1'b1) n_int_out <= n_int_out + 1;
	end
endmodule
`default_nettype wire

// ==== verif/charger_event_interrupt_masks_test.sv ====
// bench for the charger event mask block
`timescale 1ns/1ps
`default_nettype none
module charger_event_interrupt_masks_test;
	logic                 clock_in = 1'b0;
	logic                 nrst_in = 1'b0;
	cevm_pkg::cevm_bus_t  bus = '0;
	cevm_pkg::cevm_evt_t  evt = '0;
	logic [7:0]           rdata;
	logic [23:0]          flags;
	logic                 irq;
	int                   n_int;
	int                   n_fail = 0;
	int                   cmp_count = 0;
	logic [23:0]          wm;
	logic                 clk_en = 1'b1;
	always #5 clock_in = ~clock_in;
	cevm_top cevm_top_i (.clock_in(clock_in), .nrst_in(nrst_in),
		.clk_en_in(clk_en), .bus_in(bus), .rdata_out(rdata),
		.evt_in(evt), .flags_out(flags), .int_out(irq));
	cevm_host cevm_host_i (.clock_in(clock_in), .int_in(irq),
		.n_int_out(n_int));
	task automatic chk(input logic ok);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t output differs", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_in);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_in);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock_in);
		bus <= '0;
		#1 chk(rdata === e);
	endtask
	task automatic ev(input int i, input logic e);
		@(posedge clock_in);
		evt <= 24'h000001 << i;
		@(posedge clock_in);
		evt <= '0;
		#1 chk(irq === e && flags[i] === 1'b1);
	endtask
	task automatic t_reset;
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h00);
		rd(8'h2B, 8'h00);
	endtask
	task automatic t_masked;
		wr(8'h28, 8'hFF);
		wr(8'h29, 8'hFF);
		wr(8'h2A, 8'hFF);
		rd(8'h28, 8'hFF);
		rd(8'h29, 8'hD7);
		rd(8'h2A, 8'h7F);
		for (int i = 0; i < 24; i++) if (wm[i]) ev(i, 1'b0);
		chk(flags === wm);
	endtask
	task automatic t_unmasked;
		wr(cevm_pkg::OFS_CTRL, 8'h01);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h00);
		for (int i = 0; i < 24; i++) if (wm[i]) ev(i, 1'b1);
		@(posedge clock_in);
		#1 chk(n_int == $countones(wm));
	endtask
	task automatic t_freeze;
		@(posedge clock_in);
		clk_en <= 1'b0;
		wr(8'h28, 8'h55);
		@(posedge clock_in);
		evt <= 24'h000001;
		@(posedge clock_in);
		evt <= '0;
		#1 chk(irq === 1'b0);
		@(posedge clock_in);
		clk_en <= 1'b1;
		rd(8'h28, 8'h00);
	endtask
	task automatic t_midreset;
		wr(8'h28, 8'hFF);
		rd(8'h28, 8'hFF);
		@(posedge clock_in);
		nrst_in <= 1'b0;
		@(posedge clock_in);
		nrst_in <= 1'b1;
		rd(8'h28, 8'h00);
		chk(flags === 24'h000000);
	endtask
	task automatic test_done;
		$display("fails %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		wm = {cevm_pkg::WR_MASK_C, cevm_pkg::WR_MASK_B, cevm_pkg::WR_MASK_A};
		repeat (2) @(posedge clock_in);
		nrst_in <= 1'b1;
		t_reset();
		t_masked();
		t_unmasked();
		t_freeze();
		t_midreset();
		test_done();
	end
endmodule
`default_nettype wire
